// ### design/btr_pkg.sv
// btr_pkg: constants of the 8-bit basic timer with rtc mode
// assumes an 8-bit register port and a 100 MHz mclk
package btr_pkg;
  // register offsets
  localparam logic [7:0] ADDR_MODE = 8'hd8;
  localparam logic [7:0] ADDR_COUNT = 8'hd9;
  localparam logic [7:0] ADDR_STATUS = 8'hde;
  localparam logic [7:0] ADDR_MASK = 8'hdf;
  // mode register fields
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_PRE_HI = 6;
  localparam int MODE_PRE_LO = 4;
  localparam int MODE_RTC_BIT = 3;
  localparam logic [7:0] MODE_RW_MASK = 8'hf8;
  // status and mask fields
  localparam int STS_OVF = 0;
  localparam int STS_WAKE = 1;
  localparam int STS_W = 2;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [STS_W-1:0] RESET_STS = 2'h0;
  // counter and dividers
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] COUNT_FULL = 8'hff;
  localparam int PRE_W = 8;
  localparam int RTC_DIV_W = 6;
  localparam logic [RTC_DIV_W-1:0] RTC_DIV_LAST = 6'h3f;
  localparam logic [7:0] IRQ_VECTOR = 8'h08;
  // rtc source and its interval
  localparam int RTC_SRC_HZ = 32768;
  localparam real RTC_INTERVAL_S = 0.5;
  localparam int SYNC_STAGES = 3;
endpackage

// ### design/btr_tick_if.sv
// btr_tick_if: timer clock request and tick between core and divider
// assumes both ends on mclk
`timescale 1ns/1ns
`default_nettype none
interface btr_tick_if;
  logic run;
  logic rtcMode;
  logic [2:0] prescale;
  logic tick;
  modport gen (input run, input rtcMode, input prescale, output tick);
  modport core (output run, output rtcMode, output prescale, input tick);
endinterface
`default_nettype wire

// ### design/btr_tick_gen.sv
// btr_tick_gen: prescaler of the instruction clock and rtc divider
// assumes a synchronised, filtered rtc level on mclk
`timescale 1ns/1ns
`default_nettype none
module btr_tick_gen
  import btr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // rtc source level, already synchronised
  input wire logic rtcLevel,
  // to the counter core
  btr_tick_if.gen tk
);
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] preMask;
  logic [RTC_DIV_W-1:0] rtcDiv;
  logic rtcPrev;
  logic rtcRise;
  logic preHit;

  // divide by 256 at code 0 down to 2 at code 7
  assign preMask = PRE_W'(8'hff >> tk.prescale);
  assign preHit = (pre & preMask) == preMask;
  assign rtcRise = rtcLevel && !rtcPrev;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre <= '0;
    end else if (clkEn) begin
      if (!tk.run) begin
        pre <= '0;
      end else begin
        pre <= PRE_W'(pre + 1'b1);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rtcPrev <= 1'b0;
      rtcDiv <= '0;
    end else if (clkEn) begin
      rtcPrev <= rtcLevel;
      if (rtcRise) begin
        rtcDiv <= RTC_DIV_W'(rtcDiv + 1'b1);
      end
    end
  end

  // rtc tick ignores the prescale field
  assign tk.tick = tk.rtcMode ? (rtcRise && rtcDiv == RTC_DIV_LAST) : preHit;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_prescale_tick: assert property (clkEn && tk.run && !tk.rtcMode && tk.tick |->
    (pre & preMask) == preMask) else $error("prescale tick off its division");
  a_rtc_div64: assert property (tk.rtcMode && tk.tick |-> rtcDiv == 6'h3f && rtcRise)
    else $error("rtc tick not on the 64th source edge");
  a_rtc_no_pre: assert property (tk.rtcMode && !rtcRise |-> !tk.tick)
    else $error("prescaler ticks in rtc mode");
endmodule
`default_nettype wire

// ### design/btr_timer_top.sv
// btr_timer_top: 8-bit basic up timer with rtc mode and green wake
// assumes an 8-bit register port on mclk and a 32768 Hz pin
//
// Contract
// - run bit low holds, high counts
// - 8-bit counter steps once per tick
// - rollover sets sticky overflow flag
// - enabled overflow raises interrupt to vector 8
// - no reload; software rewrites the count
// - prescale field divides by 256 to 2
// - rtc select uses 32768 Hz divided by 64
// - rtc usable only with rtc build option
// - rtc mode gives 256 counts, 0.5 s
// - prescale ignored in rtc mode
// - counts in green mode, overflow wakes
// - flag sets even with interrupt disabled
`timescale 1ns/1ns
`default_nettype none
module btr_timer_top
  import btr_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // rtc source pin and build option
  input wire logic rtcClkPin,
  input wire logic rtcOptionEn,
  // power mode and wake
  input wire logic greenMode,
  output logic wakeReq,
  // interrupt
  output logic irq,
  output logic [7:0] irqVector
);
  import btr_pkg::*;

  btr_tick_if tk ();

  logic [7:0] modeReg;
  logic [CNT_W-1:0] count;
  logic [STS_W-1:0] status;
  logic [STS_W-1:0] mask;
  logic [STS_W-1:0] events;
  logic [SYNC_STAGES-1:0] rtcSync;
  logic rtcLevel;
  logic optLatched;
  logic optDone;
  logic wrMode;
  logic wrCount;
  logic wrMask;
  logic rdStatus;
  logic step;
  logic ovfEvt;
  logic [7:0] next_rdData;

  // register decode
  assign wrMode = regWr && regAddr == ADDR_MODE;
  assign wrCount = regWr && regAddr == ADDR_COUNT;
  assign wrMask = regWr && regAddr == ADDR_MASK;
  assign rdStatus = regRd && regAddr == ADDR_STATUS;

  // build option caught after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      optDone <= 1'b0;
      optLatched <= 1'b0;
    end else if (clkEn && !optDone) begin
      optDone <= 1'b1;
      optLatched <= rtcOptionEn;
    end
  end

  // rtc pin synchroniser, level moves when stages two and three agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rtcSync <= '0;
    end else if (clkEn) begin
      rtcSync <= {rtcSync[SYNC_STAGES-2:0], rtcClkPin};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rtcLevel <= 1'b0;
    end else if (clkEn && rtcSync[1] == rtcSync[2]) begin
      rtcLevel <= rtcSync[2];
    end
  end

  // mode register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      modeReg <= RESET_BYTE;
    end else if (clkEn && wrMode) begin
      modeReg <= regWrData & MODE_RW_MASK;
    end
  end

  assign tk.run = modeReg[MODE_RUN_BIT];
  assign tk.prescale = modeReg[MODE_PRE_HI:MODE_PRE_LO];
  assign tk.rtcMode = modeReg[MODE_RTC_BIT] && optLatched;

  btr_tick_gen u_tick (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .rtcLevel(rtcLevel),
    .tk(tk)
  );

  // counter: no reload, rolls on through zero
  assign step = clkEn && tk.run && tk.tick;
  assign ovfEvt = step && !wrCount && count == COUNT_FULL;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= RESET_BYTE;
    end else if (clkEn) begin
      if (wrCount) begin
        count <= regWrData;
      end else if (step) begin
        count <= CNT_W'(count + 1'b1);
      end
    end
  end

  // events keep running in green mode
  assign events[STS_OVF] = ovfEvt;
  assign events[STS_WAKE] = ovfEvt && greenMode;

  // sticky status, read clears, a new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status <= RESET_STS;
    end else if (clkEn) begin
      if (rdStatus) begin
        status <= events;
      end else begin
        status <= status | events;
      end
    end
  end

  // mask: bit 0 is the overflow interrupt enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask <= RESET_STS;
    end else if (clkEn && wrMask) begin
      mask <= regWrData[STS_W-1:0];
    end
  end

  assign irq = |(status & mask);
  assign irqVector = IRQ_VECTOR;

  // wake pulse back to the previous mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wakeReq <= 1'b0;
    end else if (clkEn) begin
      wakeReq <= events[STS_WAKE];
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    next_rdData = RESET_BYTE;
    if (regRd) begin
      unique case (regAddr)
        ADDR_MODE: next_rdData = modeReg;
        ADDR_COUNT: next_rdData = count;
        ADDR_STATUS: next_rdData = {6'h00, status};
        ADDR_MASK: next_rdData = {6'h00, mask};
        default: next_rdData = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdData <= RESET_BYTE;
    end else if (clkEn) begin
      regRdData <= next_rdData;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_hold_stopped: assert property (clkEn && !tk.run && !wrCount |=>
    count == $past(count)) else $error("count moved while stopped");
  a_count_step: assert property (step && !wrCount |=>
    count == CNT_W'($past(count) + 8'h01)) else $error("count did not step by one");
  a_ovf_flag: assert property (ovfEvt |=> status[STS_OVF])
    else $error("overflow flag not set");
  a_flag_sticky: assert property (status[STS_OVF] && !(clkEn && rdStatus) |=>
    status[STS_OVF]) else $error("overflow flag dropped without a read");
  a_irq_vector: assert property (ovfEvt && mask[STS_OVF] && !wrMask |=> irq && irqVector == 8'h08)
    else $error("enabled overflow gave no interrupt");
  a_no_reload: assert property (ovfEvt |=> count == 8'h00 ##1 (count == 8'h00
    || $past(step) || $past(wrCount))) else $error("counter reloaded on overflow");
  a_rtc_option: assert property (!optLatched |-> !tk.rtcMode)
    else $error("rtc mode without build option");
  a_green_wake: assert property (ovfEvt && greenMode |=> wakeReq ##1 !wakeReq ||
    $past(events[STS_WAKE])) else $error("green overflow did not wake");
  a_flag_no_en: assert property (ovfEvt && !mask[STS_OVF] |=>
    status[STS_OVF]) else $error("flag not set with interrupt disabled");
  a_rtc_full: assert property (tk.rtcMode && ovfEvt |=> count == 8'h00)
    else $error("rtc interval not 256 counts");

  c_overflow: cover property (ovfEvt && mask[STS_OVF] ##1 irq);
  c_rtc_ovf: cover property (tk.rtcMode && ovfEvt);
  c_green_wake: cover property (wakeReq);
  c_read_clear: cover property (status[STS_OVF] && rdStatus ##1 !status[STS_OVF]);
endmodule
`default_nettype wire

// ### verification/basic_8bit_timer_rtc_tb.sv
// basic_8bit_timer_rtc_tb: self-checking bench of the basic timer
// assumes btr_timer_top carries its own assertions, mclk at 100 MHz
`timescale 1ns/1ns
`default_nettype none
module basic_8bit_timer_rtc_tb;
  import btr_pkg::*;
  logic mclk, rst, clkEn, regWr, regRd, rtcClkPin, rtcOptionEn, greenMode;
  logic [7:0] regAddr, regWrData, rd;
  wire logic [7:0] regRdData;
  wire logic [7:0] irqVector;
  wire logic wakeReq;
  wire logic irq;
  int err_total = 0;
  int comparisons = 0;
  int wakeCnt = 0;
  int seed;
  logic [7:0] regList [5] = '{ADDR_MODE, ADDR_COUNT, ADDR_STATUS, ADDR_MASK, 8'hda};

  btr_timer_top u_dut (
    .mclk(mclk), .rst(rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rtcClkPin(rtcClkPin), .rtcOptionEn(rtcOptionEn),
    .greenMode(greenMode), .wakeReq(wakeReq), .irq(irq), .irqVector(irqVector)
  );

  always #5 mclk = ~mclk;

  // fast stand-in for the 32768 Hz source: 8 mclk per period
  always begin
    repeat (4) @(posedge mclk);
    rtcClkPin <= ~rtcClkPin;
  end

  always @(posedge mclk) begin
    if (wakeReq === 1'b1) wakeCnt++;
  end

  function automatic int div_of(input int p);
    return 256 >> p;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi,
                     input string what);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdData;
    @(posedge mclk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    logic [7:0] v;
    int m;
    mclk = 1'b0;
    rst = 1'b1;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    rtcClkPin = 1'b0;
    rtcOptionEn = 1'b1;
    greenMode = 1'b0;
    seed = 92252;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // reset values, unmapped place, read-only low mode bits
    foreach (regList[i]) begin
      rdr(regList[i], rd);
      chk(rd, RESET_BYTE, RESET_BYTE, "reset value");
    end
    chk(irqVector, 8'h08, 8'h08, "vector");
    wr(ADDR_MODE, 8'h7f);
    rdr(ADDR_MODE, rd);
    chk(rd, 8'h78, 8'h78, "mode readback");
    $display("test registers done");
    // run bit low holds the count
    v = 8'($random(seed));
    wr(ADDR_COUNT, v);
    wr(ADDR_MODE, 8'h70);
    repeat (600) @(posedge mclk);
    rdr(ADDR_COUNT, rd);
    chk(rd, v, v, "held count");
    // clock enable low freezes the prescaler and the count
    v = 8'($random(seed)) & 8'h7f;
    wr(ADDR_COUNT, v);
    wr(ADDR_MODE, 8'hf0);
    clkEn <= 1'b0;
    repeat (50) @(posedge mclk);
    clkEn <= 1'b1;
    wr(ADDR_MODE, 8'h00);
    rdr(ADDR_COUNT, rd);
    chk(rd, v + 8'd1, v + 8'd1, "frozen by clock enable");
    $display("test hold done");
    // every prescale code, random start count
    for (int p = 0; p < 8; p++) begin
      v = 8'($random(seed)) & 8'h7f;
      wr(ADDR_COUNT, v);
      wr(ADDR_MODE, 8'h80 | 8'(p << 4));
      repeat (4 * div_of(p) - 2) @(posedge mclk);
      wr(ADDR_MODE, 8'h00);
      rdr(ADDR_COUNT, rd);
      chk(rd, v + 8'd3, v + 8'd4, "prescaled count");
    end
    $display("test prescale done");
    // rollover with mask off and on, green wake when on
    for (m = 0; m < 2; m++) begin
      wr(ADDR_MASK, 8'(m));
      greenMode <= m[0];
      wr(ADDR_COUNT, 8'hfe);
      wr(ADDR_MODE, 8'hf0);
      repeat (10) @(posedge mclk);
      chk({7'd0, irq}, 8'(m), 8'(m), "irq level");
      wr(ADDR_MODE, 8'h00);
      rdr(ADDR_COUNT, rd);
      chk(rd, 8'h01, 8'h08, "count after rollover");
      rdr(ADDR_STATUS, rd);
      chk(rd, 8'(1 + 2 * m), 8'(1 + 2 * m), "status");
      rdr(ADDR_STATUS, rd);
      chk(rd, 8'h00, 8'h00, "status cleared");
      chk({7'd0, irq}, 8'h00, 8'h00, "irq dropped");
      chk(8'(wakeCnt), 8'(m), 8'(m), "wake pulses");
      greenMode <= 1'b0;
    end
    $display("test overflow done");
    // rtc mode ignores prescale, one step per 64 source edges
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_MODE, 8'hf8);
    repeat (1280) @(posedge mclk);
    wr(ADDR_MODE, 8'h00);
    rdr(ADDR_COUNT, rd);
    chk(rd, 8'h02, 8'h03, "rtc count");
    $display("test rtc done");
    report_and_stop;
  end
endmodule
`default_nettype wire
